// ### hdl/hpt_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01: Per-output PRBS enable bits 15..12 replace data while aux register bit 0 is set
// R02: Outputs 9, 10 use codes at 11-9, 8-6 while aux register bit 0 is set
// R03: Rounding bit 5 clear truncates filter output
// R04: Rounding bit set rounds filter output to nearest
// R05: y = 2^k/(2^k+1)*(x - x_prev + y_prev)
// R06: Corner exponent bits 4-1, valid 2 to 10
// R07: Corner acts only while filter enable set
// R08: Bit 0 enables filter, default off
// R09: Disabled filter passes samples unchanged
module hpt_top
  import hpt_pkg::*;
#(
  parameter int AW = 12
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        in_valid,
  input  wire hpt_pkg::hpt_bank_t in_data,
  output logic             out_valid,
  output hpt_pkg::hpt_bank_t out_data
);
  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [15:0]   ctrl_r;
  logic          aux_r;
  logic          bvalid_r;
  logic [1:0]    bresp_r;
  logic          rvalid_r;
  logic [1:0]    rresp_r;
  logic [31:0]   rdata_r;
  logic [31:0]   stat_w;
  logic [31:0]   rd_mux;
  logic          wr_go;
  logic          rd_go;
  logic          wr_ctrl;
  logic          wr_aux;
  logic          wr_hit;
  logic          rd_hit;
  logic          aw_ctrl;
  logic          aw_aux;
  logic          aw_stat;
  logic          ar_ctrl;
  logic          ar_aux;
  logic          ar_stat;
  logic          k_bad;
  logic          wr_lo;
  logic          wr_hi;
  logic          ind_sel;
  logic [`HPT_NCH-1:0] prbs_on;

  assign wr_go   = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go   = s_axi_arvalid && !rvalid_r;
  assign aw_ctrl = (s_axi_awaddr == AW'(`HPT_CTRL_ADDR));
  assign aw_aux  = (s_axi_awaddr == AW'(`HPT_AUX_ADDR));
  assign aw_stat = (s_axi_awaddr == AW'(`HPT_STAT_ADDR));
  assign ar_ctrl = (s_axi_araddr == AW'(`HPT_CTRL_ADDR));
  assign ar_aux  = (s_axi_araddr == AW'(`HPT_AUX_ADDR));
  assign ar_stat = (s_axi_araddr == AW'(`HPT_STAT_ADDR));
  assign wr_ctrl = wr_go && aw_ctrl;
  assign wr_aux  = wr_go && aw_aux;
  assign wr_lo   = wr_ctrl && s_axi_wstrb[0];
  assign wr_hi   = wr_ctrl && s_axi_wstrb[1];
  assign wr_hit  = aw_ctrl || aw_aux || aw_stat;
  assign rd_hit  = ar_ctrl || ar_aux || ar_stat;
  assign ind_sel = aux_r;
  assign k_bad   = (ctrl_r[`HPT_K_HI:`HPT_K_LO] < `HPT_K_MIN) ||
                   (ctrl_r[`HPT_K_HI:`HPT_K_LO] > `HPT_K_MAX);   // [R06]

  assign stat_w = {22'h000000, prbs_on, k_bad, ctrl_r[`HPT_EN_BIT], 3'h0, out_valid};
  assign rd_mux = ar_ctrl ? {16'h0000, ctrl_r} :
                  ar_aux  ? {31'h00000000, aux_r} :
                  ar_stat ? stat_w : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= `HPT_CTRL_RST;                                  // [R08]
    else
    begin
      if (wr_lo)
        ctrl_r[7:0] <= s_axi_wdata[7:0];
      if (wr_hi)
        ctrl_r[15:8] <= s_axi_wdata[15:8];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aux_r <= `HPT_AUX_RST;
    else if (wr_aux && s_axi_wstrb[0])
      aux_r <= s_axi_wdata[0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `HPT_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? `HPT_RESP_OKAY : `HPT_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rresp_r  <= `HPT_RESP_OKAY;
      rdata_r  <= 32'h00000000;
    end
    else if (rd_go)
    begin
      rvalid_r <= 1'b1;
      rresp_r  <= rd_hit ? `HPT_RESP_OKAY : `HPT_RESP_SLVERR;
      rdata_r  <= rd_mux;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // ****************************************************************
  // Per-channel filter and pattern selection
  // ****************************************************************
  logic [`HPT_NCH-1:0] y_vld;

  for (genvar j = 0; j < `HPT_NCH; j++)
  begin : g_ch
    hpt_smp_if                sif ();
    logic [`HPT_PRBS_W-1:0]   lfsr_r;
    logic [`HPT_DW-1:0]       ramp_r;
    logic                     tog_r;
    logic                     lfsr_fb;
    logic [2:0]               code;
    logic [`HPT_DW-1:0]       pat;
    logic [`HPT_DW-1:0]       sel;
    logic [`HPT_DW-1:0]       dout_r;

    assign sif.en      = ctrl_r[`HPT_EN_BIT];                   // [R08]
    assign sif.rnd     = ctrl_r[`HPT_ROUND_BIT];                // [R03] [R04]
    assign sif.k       = ctrl_r[`HPT_K_HI:`HPT_K_LO];           // [R06] [R07]
    assign sif.x       = in_data[j];
    assign sif.x_valid = in_valid;

    hpt_hpf #(.DW(`HPT_DW), .FW(`HPT_FW)) u_hpf
    (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sif     (sif.flt)
    );

    assign prbs_on[j] = ind_sel && ctrl_r[`HPT_PRBS_HI - j];    // [R01]
    assign code = !ind_sel ? `HPT_PAT_NORMAL :
                  (j == 0) ? ctrl_r[`HPT_CODE9_HI:`HPT_CODE9_LO] :   // [R02]
                  (j == 1) ? ctrl_r[`HPT_CODE10_HI:`HPT_CODE10_LO] : // [R02]
                  `HPT_PAT_NORMAL;
    assign pat  = (code == `HPT_PAT_ZERO)   ? {`HPT_DW{1'b0}} :
                  (code == `HPT_PAT_ONES)   ? {`HPT_DW{1'b1}} :
                  (code == `HPT_PAT_TOGGLE) ? {`HPT_DW/2{tog_r, ~tog_r}} :
                  (code == `HPT_PAT_RAMP)   ? ramp_r : sif.y;
    assign sel  = prbs_on[j] ? lfsr_r[`HPT_DW-1:0] : pat;       // [R01]
    assign lfsr_fb = lfsr_r[`HPT_PRBS_W-1] ^ lfsr_r[`HPT_PRBS_TAP-1];

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        lfsr_r <= `HPT_PRBS_SEED;
        ramp_r <= '0;
        tog_r  <= 1'b0;
        dout_r <= '0;
      end
      else if (sif.y_valid)
      begin
        lfsr_r <= {lfsr_r[`HPT_PRBS_W-2:0], lfsr_fb};
        ramp_r <= ramp_r + `HPT_DW'(1);
        tog_r  <= ~tog_r;
        dout_r <= sel;
      end
    end

    assign y_vld[j]    = sif.y_valid;
    assign out_data[j] = dout_r;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_valid <= 1'b0;
    else
      out_valid <= y_vld[0];
  end
endmodule

`default_nettype wire

// ### hdl/hpt_consts.svh
`ifndef HPT_CONSTS_SVH
`define HPT_CONSTS_SVH

// ****************************************************************
// Register map (index, byte address = index * 4)
// ****************************************************************
`define HPT_CTRL_IDX     10'h02d
`define HPT_AUX_IDX      10'h040
`define HPT_STAT_IDX     10'h041
`define HPT_CTRL_ADDR    ({`HPT_CTRL_IDX, 2'b00})
`define HPT_AUX_ADDR     ({`HPT_AUX_IDX, 2'b00})
`define HPT_STAT_ADDR    ({`HPT_STAT_IDX, 2'b00})
`define HPT_CTRL_RST     16'h0000
`define HPT_AUX_RST      1'b0

// ****************************************************************
// Control register fields
// ****************************************************************
`define HPT_PRBS_HI      15
`define HPT_CODE9_HI     11
`define HPT_CODE9_LO     9
`define HPT_CODE10_HI    8
`define HPT_CODE10_LO    6
`define HPT_ROUND_BIT    5
`define HPT_K_HI         4
`define HPT_K_LO         1
`define HPT_EN_BIT       0
`define HPT_K_MIN        4'h2
`define HPT_K_MAX        4'ha

// ****************************************************************
// Data path
// ****************************************************************
`define HPT_DW           14
`define HPT_FW           12
`define HPT_NCH          4
`define HPT_PRBS_W       23
`define HPT_PRBS_TAP     18
`define HPT_PRBS_SEED    23'h7fffff

// ****************************************************************
// Pattern codes
// ****************************************************************
`define HPT_PAT_NORMAL   3'h0
`define HPT_PAT_ZERO     3'h1
`define HPT_PAT_ONES     3'h2
`define HPT_PAT_TOGGLE   3'h3
`define HPT_PAT_RAMP     3'h4

// ****************************************************************
// Bus responses
// ****************************************************************
`define HPT_RESP_OKAY    2'h0
`define HPT_RESP_SLVERR  2'h2

`endif

// ### hdl/hpt_pkg.sv
`include "hpt_consts.svh"

package hpt_pkg;
  typedef logic signed [`HPT_DW-1:0]         hpt_sample_t;
  typedef logic [`HPT_NCH-1:0][`HPT_DW-1:0]  hpt_bank_t;
  typedef logic [3:0]                        hpt_k_t;
endpackage

// ### hdl/hpt_smp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface hpt_smp_if;
  import hpt_pkg::*;
  logic        en;
  logic        rnd;
  hpt_k_t      k;
  hpt_sample_t x;
  logic        x_valid;
  hpt_sample_t y;
  logic        y_valid;

  modport src (output en, output rnd, output k, output x, output x_valid,
               input y, input y_valid);
  modport flt (input en, input rnd, input k, input x, input x_valid,
               output y, output y_valid);
endinterface

`default_nettype wire

// ### hdl/hpt_hpf.sv
`timescale 1ns/1ps
`default_nettype none

module hpt_hpf
  import hpt_pkg::*;
#(
  parameter int DW = `HPT_DW,
  parameter int FW = `HPT_FW
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  hpt_smp_if.flt    sif
);
  localparam int SW = DW + FW + 3;

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  logic signed [SW-1:0] x1_r;
  logic signed [SW-1:0] y_r;
  logic signed [SW-1:0] x_ext;
  logic signed [SW-1:0] s_sum;
  logic signed [SW-1:0] y_nxt;
  logic signed [SW-1:0] y_adj;
  logic signed [SW-1:0] q_val;
  logic [3:0]           k_use;
  logic signed [DW-1:0] q_sat;
  logic signed [SW-1:0] max_v;
  logic signed [SW-1:0] min_v;
  hpt_sample_t          out_r;
  logic                 vld_r;

  assign x_ext = SW'(sif.x) <<< FW;
  assign k_use = (sif.k < `HPT_K_MIN) ? `HPT_K_MIN :
                 (sif.k > `HPT_K_MAX) ? `HPT_K_MAX : sif.k;   // [R06]
  assign s_sum = x_ext - x1_r + y_r;                            // [R05]
  // Gain 2^k/(2^k+1) as the series 1 - 2^-k + 2^-2k - ... - 2^-5k
  assign y_nxt = s_sum - (s_sum >>> k_use) + (s_sum >>> (2 * k_use))
               - (s_sum >>> (3 * k_use)) + (s_sum >>> (4 * k_use))
               - (s_sum >>> (5 * k_use));                       // [R05]
  assign y_adj = sif.rnd ? y_nxt + (SW'(1) <<< (FW - 1))        // [R04]
                         : y_nxt;                               // [R03]
  assign q_val = y_adj >>> FW;                                  // [R03]
  assign max_v = SW'((1 <<< (DW - 1)) - 1);
  assign min_v = -(SW'(1) <<< (DW - 1));
  assign q_sat = (q_val > max_v) ? DW'(max_v) :
                 (q_val < min_v) ? DW'(min_v) : DW'(q_val);

  // ****************************************************************
  // State and output
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !sif.en)                                    // [R09]
    begin
      x1_r <= '0;
      y_r  <= '0;
    end
    else if (sif.x_valid)                                       // [R07]
    begin
      x1_r <= x_ext;
      y_r  <= y_nxt;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_r <= '0;
      vld_r <= 1'b0;
    end
    else
    begin
      vld_r <= sif.x_valid;
      if (sif.x_valid)
        out_r <= sif.en ? q_sat : sif.x;                        // [R08] [R09]
    end
  end

  assign sif.y       = out_r;
  assign sif.y_valid = vld_r;
endmodule

`default_nettype wire

// ### sim/hpt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Checks
// ********
module hpt_monitor
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [11:0]        s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic               in_valid,
  input wire hpt_pkg::hpt_bank_t in_data,
  input wire logic               out_valid,
  input wire hpt_pkg::hpt_bank_t out_data
);
  import hpt_pkg::*;
  logic [15:0] ctl_r;
  logic        aux_r;
  wire         wr_en = s_axi_awvalid && s_axi_awready;
  wire         thru  = !ctl_r[0] && !aux_r;
  wire  [2:0]  c9    = ctl_r[11:9];
  wire  [2:0]  c10   = ctl_r[8:6];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk)
    if (!aresetn)
      {ctl_r, aux_r} <= 17'h0;
    else if (wr_en && s_axi_awaddr == 12'h0b4)
      ctl_r <= s_axi_wdata[15:0];
    else if (wr_en && s_axi_awaddr == 12'h100)
      aux_r <= s_axi_wdata[0];
  out_late_a: assert property (in_valid |-> ##2 out_valid)
    else $error("no output");
  out_extra_a: assert property (!in_valid |-> ##2 !out_valid)
    else $error("extra output");
  data_hold_a: assert property (!out_valid |-> $stable(out_data))
    else $error("output moved");
  pass_thru_a: assert property (
    in_valid && thru |-> ##2 out_data == $past(in_data, 2)) else $error("not passed");
  side_lanes_a: assert property (
    in_valid && !ctl_r[0] && ctl_r[13:12] == 2'b00 |-> ##2
    out_data[3:2] == $past(in_data[3:2], 2)) else $error("lanes 11 12 wrong");
  zero_code_a: assert property (
    in_valid && aux_r && !ctl_r[15] && c9 == 3'h1 |-> ##2 out_data[0] == '0)
    else $error("code 1 wrong");
  ones_code_a: assert property (
    in_valid && aux_r && !ctl_r[14] && c10 == 3'h2 |-> ##2 out_data[1] == '1)
    else $error("code 2 wrong");
  toggle_code_a: assert property (
    aux_r && !ctl_r[14] && c10 == 3'h3 && in_valid ##1 in_valid |-> ##2
    out_data[1] == ~$past(out_data[1])) else $error("code 3 wrong");
endmodule
bind hpt_top hpt_monitor mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .in_valid(in_valid), .in_data(in_data), .out_valid(out_valid), .out_data(out_data));
`default_nettype wire

// ### sim/hpt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Capture of output words
// ********
module hpt_host_model
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               out_valid,
  input wire hpt_pkg::hpt_bank_t out_data
);
  import hpt_pkg::*;
  hpt_bank_t q [$];
  always @(posedge aclk)
    if (aresetn && out_valid)
      q.push_back(out_data);
endmodule
`default_nettype wire

// ### sim/hpt_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench
// ********
module hpt_tb_top;
  import hpt_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, in_valid, out_valid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  hpt_bank_t   in_data, out_data;
  int          err_total, tests_run;
  wire  [3:0]  hs = {rvalid, arready, bvalid, awready && wready};
  hpt_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_valid(in_valid), .in_data(in_data), .out_valid(out_valid), .out_data(out_data));
  hpt_host_model host (.aclk(aclk), .aresetn(aresetn), .out_valid(out_valid),
    .out_data(out_data));
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt(input int s);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (hs[s] !== 1'b1 && n < 99);
    if (n == 99)
    begin
      err_total++;
      final_report();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wt(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wt(1);
    bready <= 1'b0;
    chk(bresp, e);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [1:0] e, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wt(2);
    arvalid <= 1'b0;
    wt(3);
    rready <= 1'b0;
    d = rdata;
    chk(rresp, e);
    @(posedge aclk);
  endtask
  task automatic run(input int n, input hpt_bank_t b);
    host.q.delete();
    in_data <= b;
    in_valid <= 1'b1;
    repeat (n) @(posedge aclk);
    in_valid <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(host.q.size(), n);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    rd(12'h0b4, 2'h0, d);
    chk(d, 0);
    rd(12'h010, 2'h2, d);
    chk(d, 0);
    wr(12'h010, 32'h1, 2'h2);
    wr(12'h0b4, 32'h3e, 2'h0);
    rd(12'h0b4, 2'h0, d);
    chk(d, 32'h3e);
    run(4, {14'h1abc, 14'h2001, 14'h0123, 14'h3fff});
    foreach (host.q[i]) chk(host.q[i], {14'h1abc, 14'h2001, 14'h0123, 14'h3fff});
    $display("t_regs end");
  endtask
  task automatic t_codes();
    hpt_bank_t   b;
    logic [13:0] e;
    b = {14'h0f0f, 14'h1234, 14'h0555, 14'h2aaa};
    wr(12'h100, 32'h1, 2'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(12'h0b4, c * 32'h240, 2'h0);
      run(3, b);
      for (int i = 0; i < 2; i++)
      begin
        e = c == 1 ? 14'h0 : c == 2 ? 14'h3fff : c == 3 ? ~host.q[0][i] : b[i];
        e = c == 4 ? host.q[0][i] + 14'h1 : e;
        chk(host.q[1][i], e);
      end
      chk(host.q[2][3:2], b[3:2]);
    end
    $display("t_codes end");
  endtask
  task automatic t_prbs();
    hpt_bank_t   b;
    int          m;
    logic [31:0] d;
    b = {14'h0111, 14'h0222, 14'h0333, 14'h0444};
    m = 0;
    wr(12'h0b4, 32'ha200, 2'h0);
    rd(12'h104, 2'h0, d);
    chk(d, 32'h160);
    run(6, b);
    foreach (host.q[i])
    begin
      m += int'(host.q[i][0] != b[0] && host.q[i][0] != 0) + int'(host.q[i][2] != b[2]);
      chk({host.q[i][3], host.q[i][1]}, {b[3], b[1]});
    end
    chk(m > 9, 1);
    wr(12'h100, 32'h0, 2'h0);
    run(3, b);
    foreach (host.q[i]) chk(host.q[i], b);
    $display("t_prbs end");
  endtask
  task automatic fl(input logic [15:0] v, output int r [6]);
    int  k;
    real g, y;
    k = v[4:1];
    g = 2.0 ** k / (2.0 ** k + 1.0);
    y = 0.0;
    wr(12'h0b4, 32'h0, 2'h0);
    wr(12'h0b4, {16'h0, v}, 2'h0);
    run(6, {4{14'd1001}});
    for (int i = 0; i < 6; i++)
    begin
      y = g * ((i == 0 ? 1001.0 : 0.0) + y);
      r[i] = $signed(host.q[i][0]);
      chk(r[i] - y < 2.5 && y - r[i] < 2.5, 1);
    end
  endtask
  task automatic t_filt();
    int a [6];
    int b [6];
    int m;
    m = 0;
    fl(16'h0005, a);
    fl(16'h0025, b);
    for (int i = 0; i < 6; i++)
    begin
      chk((b[i] - a[i]) inside {0, 1}, 1);
      m += b[i] - a[i];
    end
    chk(m > 0, 1);
    fl(16'h0035, a);
    $display("t_filt end");
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, in_valid} = '0;
    {awaddr, araddr, wdata, in_data} = '0;
    err_total = 0;
    tests_run = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_codes();
    t_prbs();
    t_filt();
    final_report();
  end
endmodule
`default_nettype wire
